// [verilog/poly_edge_regs.svh]
// Purpose: constants for the polygon mode and edge command handler
// Assumes: one clock, commands arrive pre-parsed as one-cycle strobes
// Notes:   error numbers and mode codes as used by the command set
`ifndef POLY_EDGE_REGS_SVH
`define POLY_EDGE_REGS_SVH
// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define MODE_CODE_START   2'h0
`define MODE_CODE_CLOSE   2'h1
`define MODE_CODE_EXIT    2'h2
// ----------------------------------------------------------------
// error numbers
// ----------------------------------------------------------------
`define ERR_NONE          4'h0
`define ERR_ILLEGAL       4'h1
`define ERR_PARAMS        4'h2
`define ERR_BAD_CODE      4'h3
`define ERR_OVERFLOW      4'h7
// ----------------------------------------------------------------
// store
// ----------------------------------------------------------------
`define STORE_DEPTH       127
`endif

// [verilog/poly_edge_pkg.sv]
// Purpose: types for the polygon mode and edge command handler
// Assumes: nothing beyond the constants header
// Notes:   command kinds seen by the interpreter
package poly_edge_pkg;
	typedef enum logic [3:0] {
		CMD_POLY_MODE = 4'h0,
		CMD_EDGE      = 4'h1,
		CMD_FILL      = 4'h2,
		CMD_CIRCLE    = 4'h3,
		CMD_PLOT      = 4'h4,
		CMD_PEN_UP    = 4'h5,
		CMD_PEN_DOWN  = 4'h6,
		CMD_STORABLE  = 4'h7,
		CMD_OUTPUT    = 4'h8,
		CMD_INIT      = 4'h9,
		CMD_RECT      = 4'ha,
		CMD_WEDGE     = 4'hb,
		CMD_OTHER     = 4'hc
	} cmd_kind_t;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_DEFINE = 5'b00010,
		ST_EDGE   = 5'b00100,
		ST_RESTOR = 5'b01000,
		ST_DONE   = 5'b10000
	} state_t;
endpackage

// [verilog/vertex_store.sv]
// Purpose: polygon vertex memory with pen-state bit per entry
// Assumes: one write or one read per cycle
// Notes:   write beyond depth is refused and reported; write with clear lands in entry 0
module vertex_store #(
	parameter int DEPTH = 127,
	parameter int CW    = 24
) (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	// control
	input  wire logic                     clear,
	input  wire logic                     wr_en,
	input  wire logic [CW-1:0]            wr_x,
	input  wire logic [CW-1:0]            wr_y,
	input  wire logic                     wr_down,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	// status
	output logic      [CW-1:0]            rd_x,
	output logic      [CW-1:0]            rd_y,
	output logic                          rd_down,
	output logic      [$clog2(DEPTH+1)-1:0] count,
	output logic                          overflow
);
	logic [2*CW:0] mem [DEPTH];
	logic          full;
	assign full = (count == ($clog2(DEPTH+1))'(DEPTH));
	// no reset on the array: contents are qualified by count
	always_ff @(posedge core_clk) begin
		if (wr_en && (clear || !full)) begin
			mem[clear ? '0 : count[$clog2(DEPTH)-1:0]] <= {wr_down, wr_x, wr_y};
		end
	end
	assign {rd_down, rd_x, rd_y} = mem[rd_addr];
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count    <= '0;
			overflow <= 1'b0;
		end else if (clear) begin
			count    <= wr_en ? ($clog2(DEPTH+1))'(1) : '0;
			overflow <= 1'b0;
		end else if (wr_en) begin
			if (full) begin
				overflow <= 1'b1;
			end else begin
				count <= count + 1'b1;
			end
		end
	end
endmodule

// [verilog/poly_edge_handler.sv]
// Purpose: polygon definition mode and edge command interpreter
// Assumes: host commands pre-parsed into one-cycle strobes
// Notes:   drawing output is a stream of moves to the pen drive
//
// Contract
// RL1 - code 0 start, 1 close sub, 2 exit
// RL2 - missing code means code zero, no error
// RL3 - bad code discarded, error 3 recorded
// RL4 - close codes outside mode silently ignored
// RL5 - illegal instruction in mode gives error 1
// RL6 - points past store full dropped, error 7
// RL7 - no drawing output while definition mode open
// RL8 - lost pen state discards polygon mode command
// RL9 - stored polygons drawn only by fill/edge
// RL10 - circle is a whole closed subpolygon
// RL11 - point after circle starts new subpolygon
// RL12 - close adds closing vertex if still open
// RL13 - circle self-lowers pen, returns to centre
// RL14 - host places pen at centre first
// RL15 - edge outlines whatever polygon is stored
// RL16 - edge leaves store contents intact
// RL17 - edge draws pen-down vertices, current pen
// RL18 - edge restores pen position and state
// RL19 - overflowed store edges kept points only
// RL20 - edge with no polygon discarded silently
// RL21 - edge with parameters: error 2, still edges
// RL22 - exit restores pen state before code 0
// RL23 - last error held for readback
`include "poly_edge_regs.svh"
module poly_edge_handler #(
	parameter int CW    = 24,
	parameter int DEPTH = `STORE_DEPTH
) (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	// command in
	input  wire logic                    cmd_valid,
	input  poly_edge_pkg::cmd_kind_t     cmd_kind,
	input  wire logic                    cmd_has_param,
	input  wire logic [7:0]              cmd_param,
	input  wire logic [CW-1:0]           cmd_x,
	input  wire logic [CW-1:0]           cmd_y,
	input  wire logic                    pen_lost,
	// pen state from datapath
	input  wire logic [CW-1:0]           pen_x,
	input  wire logic [CW-1:0]           pen_y,
	input  wire logic                    pen_is_down,
	// drawing out
	output logic                         draw_valid,
	output logic [CW-1:0]                draw_x,
	output logic [CW-1:0]                draw_y,
	output logic                         draw_down,
	output logic                         pass_through,
	output logic                         busy,
	// error and mode status
	output logic [3:0]                   error_num,
	output logic                         error_pulse,
	output logic                         poly_mode
);
	import poly_edge_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int NW = $clog2(DEPTH+1);
	state_t          state_r;
	logic            defined_r;
	logic            sub_open_r;
	logic            start_pend_r;
	logic [CW-1:0]   sub_x_r, sub_y_r;
	logic [CW-1:0]   save_x_r, save_y_r;
	logic            save_down_r;
	logic            pen_dn_r;
	logic [AW-1:0]   rd_ptr_r;
	logic            st_clear, st_wr, st_wr_down;
	logic [CW-1:0]   st_x, st_y;
	logic [CW-1:0]   rd_x, rd_y;
	logic            rd_down;
	logic [NW-1:0]   st_count;
	logic            st_ovf;
	logic            in_mode, mode_ok, mode_bad;
	logic [1:0]      mode_code;
	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	function automatic logic storable(input cmd_kind_t k);
		storable = (k == CMD_POLY_MODE) || (k == CMD_PLOT) || (k == CMD_PEN_UP) ||
			(k == CMD_PEN_DOWN) || (k == CMD_CIRCLE) || (k == CMD_STORABLE) ||
			(k == CMD_OUTPUT) || (k == CMD_INIT);
	endfunction
	assign in_mode = (state_r == ST_DEFINE);
	assign mode_code = cmd_has_param ? cmd_param[1:0] : `MODE_CODE_START; // RL2
	assign mode_bad  = cmd_has_param && (cmd_param > 8'h02); // RL3
	assign mode_ok   = cmd_valid && (cmd_kind == CMD_POLY_MODE) && !pen_lost && !mode_bad; // RL8
	// ----------------------------------------------------------------
	// store write mux
	// ----------------------------------------------------------------
	logic cmd_pt, cmd_circ, close_req, start_req;
	assign start_req = mode_ok && (mode_code == `MODE_CODE_START) && (state_r != ST_EDGE)
		&& (state_r != ST_RESTOR); // RL1
	assign close_req = mode_ok && in_mode && (mode_code != `MODE_CODE_START); // RL4
	assign cmd_pt    = cmd_valid && in_mode && (cmd_kind == CMD_PLOT);
	assign cmd_circ  = cmd_valid && in_mode && (cmd_kind == CMD_CIRCLE);
	always_comb begin
		st_clear   = start_req;
		st_wr      = 1'b0;
		st_x       = cmd_x;
		st_y       = cmd_y;
		st_wr_down = pen_dn_r;
		if (start_req) begin
			// pen before the start is the first vertex
			st_wr      = 1'b1; // RL1
			st_x       = pen_x;
			st_y       = pen_y;
			st_wr_down = pen_is_down;
		end else if (close_req && sub_open_r) begin
			// closing vertex back to subpolygon start
			st_wr      = 1'b1; // RL12
			st_x       = sub_x_r;
			st_y       = sub_y_r;
		end else if (cmd_circ) begin
			// circle centre entry; outline tessellated by the datapath
			st_wr      = 1'b1; // RL10
			st_x       = save_x_r;
			st_y       = save_y_r;
			st_wr_down = 1'b1; // RL13
		end else if (cmd_pt) begin
			st_wr      = 1'b1;
			st_wr_down = start_pend_r ? 1'b0 : pen_dn_r; // RL11
		end
	end
	vertex_store #(
		.DEPTH (DEPTH),
		.CW    (CW)
	) u_store (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clear    (st_clear),
		.wr_en    (st_wr),
		.wr_x     (st_x),
		.wr_y     (st_y),
		.wr_down  (st_wr_down),
		.rd_addr  (rd_ptr_r),
		.rd_x     (rd_x),
		.rd_y     (rd_y),
		.rd_down  (rd_down),
		.count    (st_count),
		.overflow (st_ovf)
	);
	// ----------------------------------------------------------------
	// subpolygon tracking
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sub_open_r   <= 1'b0;
			start_pend_r <= 1'b0;
			sub_x_r      <= '0;
			sub_y_r      <= '0;
			pen_dn_r     <= 1'b0;
		end else if (start_req) begin
			sub_open_r   <= 1'b0;
			start_pend_r <= 1'b0;
			sub_x_r      <= pen_x;
			sub_y_r      <= pen_y;
			pen_dn_r     <= pen_is_down;
		end else if (in_mode && cmd_valid) begin
			if (close_req || cmd_circ) begin
				sub_open_r   <= 1'b0; // RL10
				start_pend_r <= 1'b1; // RL11
			end else if (cmd_pt) begin
				if (start_pend_r) begin
					sub_x_r <= cmd_x;
					sub_y_r <= cmd_y;
				end
				start_pend_r <= 1'b0;
				sub_open_r   <= (cmd_x != sub_x_r) || (cmd_y != sub_y_r) || start_pend_r;
			end else if (cmd_kind == CMD_PEN_DOWN) begin
				pen_dn_r <= 1'b1;
			end else if (cmd_kind == CMD_PEN_UP) begin
				pen_dn_r <= 1'b0;
			end
		end
	end
	// ----------------------------------------------------------------
	// main sequencer
	// ----------------------------------------------------------------
	logic edge_go;
	assign edge_go = cmd_valid && (cmd_kind == CMD_EDGE) && (state_r == ST_IDLE)
		&& defined_r && (st_count != '0); // RL15 RL20
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r     <= ST_IDLE;
			defined_r   <= 1'b0;
			rd_ptr_r    <= '0;
			save_x_r    <= '0;
			save_y_r    <= '0;
			save_down_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start_req) begin
						state_r     <= ST_DEFINE;
						defined_r   <= 1'b0;
						save_x_r    <= pen_x;
						save_y_r    <= pen_y;
						save_down_r <= pen_is_down;
					end else if (edge_go) begin
						state_r     <= ST_EDGE;
						rd_ptr_r    <= '0;
						save_x_r    <= pen_x; // RL18
						save_y_r    <= pen_y;
						save_down_r <= pen_is_down;
					end else if (cmd_valid && (cmd_kind == CMD_RECT || cmd_kind == CMD_WEDGE)) begin
						defined_r   <= 1'b1; // RL15
					end
				end
				ST_DEFINE: begin
					if (cmd_valid && cmd_kind == CMD_INIT) begin
						state_r   <= ST_IDLE;
						defined_r <= 1'b0;
					end else if (close_req && mode_code == `MODE_CODE_EXIT) begin
						state_r   <= ST_RESTOR; // RL22
						defined_r <= 1'b1;
					end
				end
				ST_EDGE: begin
					// only the kept points are walked
					if ({1'b0, rd_ptr_r} + 1'b1 >= NW'(st_count)) begin // RL19
						state_r <= ST_RESTOR;
					end else begin
						rd_ptr_r <= rd_ptr_r + 1'b1;
					end
				end
				ST_RESTOR: begin
					state_r <= ST_DONE;
				end
				ST_DONE: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// drawing output
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			draw_valid   <= 1'b0;
			draw_x       <= '0;
			draw_y       <= '0;
			draw_down    <= 1'b0;
			pass_through <= 1'b1;
			busy         <= 1'b0;
			poly_mode    <= 1'b0;
		end else begin
			draw_valid   <= 1'b0;
			pass_through <= (state_r == ST_IDLE) && !start_req; // RL7 RL9
			busy         <= (state_r != ST_IDLE) && (state_r != ST_DEFINE);
			poly_mode    <= in_mode || start_req;
			if (state_r == ST_EDGE) begin
				// store read only; never written here
				draw_valid <= 1'b1; // RL16
				draw_x     <= rd_x;
				draw_y     <= rd_y;
				draw_down  <= rd_down; // RL17
			end else if (state_r == ST_RESTOR) begin
				draw_valid <= 1'b1; // RL18 RL22
				draw_x     <= save_x_r;
				draw_y     <= save_y_r;
				draw_down  <= save_down_r;
			end
		end
	end
	// ----------------------------------------------------------------
	// error recording
	// ----------------------------------------------------------------
	logic       err_set;
	logic [3:0] err_val;
	logic       ovf_d_r;
	always_comb begin
		err_set = 1'b0;
		err_val = `ERR_NONE;
		if (cmd_valid && cmd_kind == CMD_POLY_MODE && !pen_lost && mode_bad) begin
			err_set = 1'b1; // RL3
			err_val = `ERR_BAD_CODE;
		end else if (cmd_valid && in_mode && !storable(cmd_kind)) begin
			err_set = 1'b1; // RL5
			err_val = `ERR_ILLEGAL;
		end else if (edge_go && cmd_has_param) begin
			err_set = 1'b1; // RL21
			err_val = `ERR_PARAMS;
		end else if (st_ovf && !ovf_d_r) begin
			err_set = 1'b1; // RL6
			err_val = `ERR_OVERFLOW;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			error_num   <= `ERR_NONE;
			error_pulse <= 1'b0;
			ovf_d_r     <= 1'b0;
		end else begin
			ovf_d_r     <= st_ovf;
			error_pulse <= err_set;
			if (err_set) begin
				error_num <= err_val; // RL23
			end
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_NO_DRAW_IN_MODE: assert property (@(posedge core_clk) disable iff (!resetn) // RL7
		in_mode |=> !pass_through)
		else $error("drawing passed while defining");
	AST_BAD_CODE_ERR: assert property (@(posedge core_clk) disable iff (!resetn) // RL3
		(cmd_valid && cmd_kind == CMD_POLY_MODE && !pen_lost && mode_bad)
		|=> (error_num == 4'h3) && error_pulse)
		else $error("bad code did not record 3");
	AST_LOST_IGNORED: assert property (@(posedge core_clk) disable iff (!resetn) // RL8
		(cmd_valid && cmd_kind == CMD_POLY_MODE && pen_lost && state_r == ST_IDLE)
		|=> state_r == ST_IDLE)
		else $error("lost pen did not discard");
	AST_CLOSE_OUTSIDE: assert property (@(posedge core_clk) disable iff (!resetn) // RL4
		(state_r == ST_IDLE && mode_ok && mode_code != 2'h0) |=> state_r == ST_IDLE)
		else $error("close outside mode acted");
	AST_ILLEGAL_ERR: assert property (@(posedge core_clk) disable iff (!resetn) // RL5
		(cmd_valid && in_mode && cmd_kind == CMD_OTHER) |=> error_num == 4'h1)
		else $error("illegal in mode not flagged");
	AST_EDGE_PARAM: assert property (@(posedge core_clk) disable iff (!resetn) // RL21
		(edge_go && cmd_has_param) |=> (error_num == 4'h2) && state_r == ST_EDGE)
		else $error("edge with parameter mishandled");
	AST_EDGE_EMPTY: assert property (@(posedge core_clk) disable iff (!resetn) // RL20
		(cmd_valid && cmd_kind == CMD_EDGE && !defined_r && state_r == ST_IDLE)
		|=> state_r == ST_IDLE && !error_pulse)
		else $error("edge without polygon acted");
	AST_EDGE_RESTORE: assert property (@(posedge core_clk) disable iff (!resetn) // RL18
		(state_r == ST_RESTOR) |=> draw_valid && draw_x == save_x_r && draw_y == save_y_r)
		else $error("pen not restored");
	AST_EXIT_RESTORE: assert property (@(posedge core_clk) disable iff (!resetn) // RL22
		(close_req && mode_code == 2'h2) |=> state_r == ST_RESTOR)
		else $error("exit did not restore");
	AST_OVF_ERR: assert property (@(posedge core_clk) disable iff (!resetn) // RL6
		$rose(st_ovf) |=> error_num == 4'h7)
		else $error("overflow not flagged");
endmodule

// [tb/plot_host_model.sv]
// Purpose: host stand-in driving parsed command strobes and pen state
// Assumes: inputs change at the falling edge, one command per call
// Notes:   waits out busy first, since the handler drops commands then
module plot_host_model #(
	parameter int CW = 24
) (
	// clock and status
	input  wire logic               core_clk,
	input  wire logic               busy,
	// command strobes
	output logic                    cmd_valid,
	output poly_edge_pkg::cmd_kind_t cmd_kind,
	output logic                    cmd_has_param,
	output logic [7:0]              cmd_param,
	output logic [CW-1:0]           cmd_x,
	output logic [CW-1:0]           cmd_y,
	// pen datapath state
	output logic                    pen_lost,
	output logic [CW-1:0]           pen_x,
	output logic [CW-1:0]           pen_y,
	output logic                    pen_is_down
);
	timeunit 1ns;
	timeprecision 1ns;
	import poly_edge_pkg::*;

	initial begin
		cmd_valid = 1'b0;
		cmd_kind = CMD_OTHER;
		cmd_has_param = 1'b0;
		cmd_param = 8'h00;
		cmd_x = '0;
		cmd_y = '0;
		pen_lost = 1'b0;
		pen_x = '0;
		pen_y = '0;
		pen_is_down = 1'b0;
	end

	task automatic send(input cmd_kind_t k, input logic hp, input logic [7:0] p,
			input logic [CW-1:0] x, input logic [CW-1:0] y);
		int n;
		n = 0;
		@(negedge core_clk);
		while (busy !== 1'b0 && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_has_param = hp;
		cmd_param = p;
		cmd_x = x;
		cmd_y = y;
		@(negedge core_clk);
		// stale fields flipped so a late sample shows up
		cmd_valid = 1'b0;
		cmd_kind = CMD_OTHER;
		cmd_param = ~p;
		cmd_x = ~x;
		cmd_y = ~y;
	endtask

	task automatic set_pen(input logic [CW-1:0] x, input logic [CW-1:0] y,
			input logic d, input logic lost);
		@(negedge core_clk);
		pen_x = x;
		pen_y = y;
		pen_is_down = d;
		pen_lost = lost;
	endtask
endmodule

// [tb/poly_edge_handler_test.sv]
// Purpose: self-checking bench for the polygon mode and edge handler
// Assumes: store depth shrunk to 8 so overflow is quick to reach
// Notes:   draw moves and error pulses logged at the falling edge
module poly_edge_handler_test;
	timeunit 1ns;
	timeprecision 1ns;
	import poly_edge_pkg::*;
	localparam int CW = 24;
	localparam int DEPTH = 8;

	logic core_clk, resetn, cmd_valid, cmd_has_param, pen_lost, pen_is_down;
	cmd_kind_t cmd_kind;
	logic [7:0] cmd_param;
	logic [CW-1:0] cmd_x, cmd_y, pen_x, pen_y, draw_x, draw_y;
	logic draw_valid, draw_down, pass_through, busy, error_pulse, poly_mode;
	logic [3:0] error_num;
	logic [2*CW:0] moves[$];
	logic [2*CW:0] exp_sq[6];
	int n_fail, samples_checked, n_err, n0, hit;

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	plot_host_model #(.CW(CW)) host (.core_clk(core_clk), .busy(busy),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_has_param(cmd_has_param),
		.cmd_param(cmd_param), .cmd_x(cmd_x), .cmd_y(cmd_y), .pen_lost(pen_lost),
		.pen_x(pen_x), .pen_y(pen_y), .pen_is_down(pen_is_down));

	poly_edge_handler #(.CW(CW), .DEPTH(DEPTH)) dut (.core_clk(core_clk),
		.resetn(resetn), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_has_param(cmd_has_param), .cmd_param(cmd_param), .cmd_x(cmd_x),
		.cmd_y(cmd_y), .pen_lost(pen_lost), .pen_x(pen_x), .pen_y(pen_y),
		.pen_is_down(pen_is_down), .draw_valid(draw_valid), .draw_x(draw_x),
		.draw_y(draw_y), .draw_down(draw_down), .pass_through(pass_through),
		.busy(busy), .error_num(error_num), .error_pulse(error_pulse),
		.poly_mode(poly_mode));

	// ------------------------------------------------------------
	// monitors and helpers
	// ------------------------------------------------------------
	always @(negedge core_clk) begin
		if (draw_valid === 1'b1)
			moves.push_back({draw_down, draw_x, draw_y});
		if (error_pulse === 1'b1)
			n_err++;
	end

	function automatic logic [2*CW:0] mv(input logic d, input int x, input int y);
		return {d, x[CW-1:0], y[CW-1:0]};
	endfunction

	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// settle long enough for any edge or restore to run out
	task automatic cmd(input cmd_kind_t k, input logic hp, input logic [7:0] p,
			input int x, input int y);
		int n;
		n = 0;
		host.send(k, hp, p, x[CW-1:0], y[CW-1:0]);
		repeat (3) @(negedge core_clk);
		while (busy !== 1'b0 && n < 500) begin
			@(negedge core_clk);
			n++;
		end
		repeat (3) @(negedge core_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_idle_refusals();
		check(pass_through === 1'b1 && poly_mode === 1'b0 && busy === 1'b0, "reset");
		check(error_num === 4'h0, "reset error");
		host.set_pen(24'h10, 24'h10, 1'b0, 1'b0);
		n0 = n_err;
		cmd(CMD_POLY_MODE, 1'b1, 8'h01, 0, 0);
		cmd(CMD_POLY_MODE, 1'b1, 8'h02, 0, 0);
		check(poly_mode === 1'b0 && n_err == n0, "close outside mode acted");
		cmd(CMD_EDGE, 1'b0, 8'h00, 0, 0);
		check(moves.size() == 0 && n_err == n0, "edge with no polygon");
		host.set_pen(24'h10, 24'h10, 1'b0, 1'b1);
		cmd(CMD_POLY_MODE, 1'b1, 8'h00, 0, 0);
		check(poly_mode === 1'b0 && n_err == n0, "start while lost");
		host.set_pen(24'h10, 24'h10, 1'b0, 1'b0);
	endtask

	task automatic t_define_square();
		n0 = n_err;
		cmd(CMD_POLY_MODE, 1'b0, 8'h55, 0, 0);
		check(poly_mode === 1'b1 && pass_through === 1'b0 && n_err == n0, "bare start");
		cmd(CMD_POLY_MODE, 1'b1, 8'h05, 0, 0);
		check(n_err == n0 + 1 && error_num === 4'h3 && poly_mode === 1'b1, "bad code");
		cmd(CMD_OTHER, 1'b0, 8'h00, 0, 0);
		check(n_err == n0 + 2 && error_num === 4'h1, "illegal in mode");
		cmd(CMD_PEN_DOWN, 1'b0, 8'h00, 0, 0);
		cmd(CMD_PLOT, 1'b1, 8'h00, 32, 16);
		cmd(CMD_PLOT, 1'b1, 8'h00, 32, 32);
		cmd(CMD_PLOT, 1'b1, 8'h00, 16, 32);
		check(moves.size() == 0, "drawing while defining");
		cmd(CMD_POLY_MODE, 1'b1, 8'h02, 0, 0);
		check(poly_mode === 1'b0 && pass_through === 1'b1, "exit code");
		check(moves.size() == 1 && moves[0] === mv(0, 16, 16), "exit restore");
	endtask

	task automatic t_edge_square();
		exp_sq = '{mv(0, 16, 16), mv(1, 32, 16), mv(1, 32, 32), mv(1, 16, 32),
			mv(1, 16, 16), mv(1, 48, 48)};
		host.set_pen(24'h30, 24'h30, 1'b1, 1'b0);
		for (int pass = 0; pass < 2; pass++) begin
			moves.delete();
			n0 = n_err;
			cmd(CMD_EDGE, pass[0], 8'h03, 0, 0);
			check(moves.size() == 6, "edge move count");
			for (int i = 0; i < 6 && i < moves.size(); i++)
				check(moves[i] === exp_sq[i], "edge move");
			if (pass == 0)
				check(n_err == n0, "plain edge error");
			else
				check(n_err == n0 + 1 && error_num === 4'h2, "edge params");
		end
	endtask

	task automatic t_circle();
		host.set_pen(24'h40, 24'h40, 1'b0, 1'b0);
		cmd(CMD_POLY_MODE, 1'b1, 8'h00, 0, 0);
		cmd(CMD_CIRCLE, 1'b1, 8'h00, 0, 0);
		cmd(CMD_PLOT, 1'b1, 8'h00, 80, 64);
		cmd(CMD_POLY_MODE, 1'b1, 8'h02, 0, 0);
		moves.delete();
		cmd(CMD_EDGE, 1'b0, 8'h00, 0, 0);
		hit = 0;
		for (int i = 0; i + 1 < moves.size(); i++)
			if (moves[i] === mv(1, 64, 64) && moves[i+1] === mv(0, 80, 64))
				hit = 1;
		check(hit == 1, "circle subpolygon");
	endtask

	task automatic t_overflow();
		host.set_pen(24'h0, 24'h0, 1'b1, 1'b0);
		cmd(CMD_POLY_MODE, 1'b1, 8'h00, 0, 0);
		n0 = n_err;
		for (int i = 1; i <= DEPTH + 2; i++)
			cmd(CMD_PLOT, 1'b1, 8'h00, i, 0);
		check(n_err == n0 + 1 && error_num === 4'h7, "overflow error");
		cmd(CMD_POLY_MODE, 1'b1, 8'h02, 0, 0);
		moves.delete();
		n0 = n_err;
		cmd(CMD_EDGE, 1'b0, 8'h00, 0, 0);
		check(moves.size() == DEPTH + 1 && n_err == n0, "edge after overflow");
		if (moves.size() > DEPTH - 1)
			check(moves[DEPTH-1][2*CW-1:CW] === 24'(DEPTH - 1), "kept point");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// tests need well under 3000 cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		n_fail = 0;
		samples_checked = 0;
		n_err = 0;
		resetn = 1'b0;
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		repeat (2) @(negedge core_clk);
		t_idle_refusals();
		t_define_square();
		t_edge_square();
		t_circle();
		t_overflow();
		print_verdict();
	end
endmodule
